// >>> design/spf_ms_timer.sv
// millisecond enable divider feeding the keepalive countdown
// assumes clk at the package clock rate
`timescale 1ns/1ps
module spf_ms_timer import spf_pkg::*; #(
  parameter int CYC_MS = CYC_PER_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // restart and tick
  input wire logic restart,
  output logic ms_tick
);
  logic [31:0] cnt;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 32'h0000_0000;
    end else if (restart || cnt == 32'(CYC_MS - 1)) begin
      cnt <= 32'h0000_0000;
    end else begin
      cnt <= cnt + 32'h0000_0001;
    end
  end

  assign ms_tick = !restart && (cnt == 32'(CYC_MS - 1));
endmodule

// >>> design/spf_pkg.sv
// package for the stream pacing and keepalive block
// assumes a single 125 MHz clock that doubles as the timestamp tick
package spf_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PKT_SIZE = 8'h00;
  localparam logic [7:0] OFS_GAP = 8'h04;
  localparam logic [7:0] OFS_DEST_IP = 8'h08;
  localparam logic [7:0] OFS_TICK_RATE = 8'h0C;
  localparam logic [7:0] OFS_KA_TIMEOUT = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  // ----------------------------------------------------------------
  // reset values, tick rate and keepalive timeout limits
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_PKT_SIZE = 16'h0578;
  localparam logic [31:0] RST_GAP = 32'h0000_0190;
  localparam logic [31:0] RST_DEST_IP = 32'h0000_0000;
  localparam logic [15:0] RST_KA_TIMEOUT = 16'h0BB8;
  localparam logic [31:0] TICK_RATE_HZ = 32'h0773_5940;
  localparam logic [15:0] KA_MIN_MS = 16'h01F4;
  localparam logic [15:0] KA_MAX_MS = 16'h2710;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  // ----------------------------------------------------------------
  // field positions, irq width and multicast first-octet range
  // ----------------------------------------------------------------
  localparam int CTRL_KA_DIS = 0;
  localparam int CTRL_STREAM_EN = 1;
  localparam int CTRL_LINK_REOPEN = 2;
  localparam int IRQ_PKT_DONE = 0;
  localparam int IRQ_KA_EXPIRED = 1;
  localparam int IRQ_W = 2;
  localparam logic [7:0] MCAST_LO = 8'hE0;
  localparam logic [7:0] MCAST_HI = 8'hEF;
endpackage

// >>> design/spf_stream_pacer.sv
// stream packet pacing, destination and keepalive supervision, APB slave
// assumes tx side streams bytes on tx_byte_valid/tx_byte_ready, one clock
//
// What this block does
// [R1] packet size counts headers and payload together
// [R2] packet size resets to 1400 bytes
// [R3] idle the gap ticks between consecutive packets
// [R4] gap resets to 400 ticks
// [R5] tick is 125 MHz, readable rate register
// [R6] zero gap allowed, larger gap slows rate
// [R7] packets go to the destination register address
// [R8] 224 to 239 first octet flags multicast
// [R9] host must message before timeout expires
// [R10] timeout expiry raises error, drops connection
// [R11] timeout in ms, 500 to 10000
// [R12] timeout resets to 3000 ms
// [R13] supervision on after reset, disable bit stops
// [R14] gap count starts after last byte
// [R15] valid control message reloads the keepalive timer
`timescale 1ns/1ps
module spf_stream_pacer import spf_pkg::*; #(
  parameter int CYC_MS = CYC_PER_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // image source
  input wire logic frame_data_pending,
  // transmitter byte stream
  output logic tx_byte_valid,
  input wire logic tx_byte_ready,
  output logic tx_first,
  output logic tx_last,
  output logic [31:0] tx_dest_ip,
  output logic tx_multicast,
  // control link
  input wire logic ctrl_msg_valid,
  output logic link_open,
  output logic ka_error,
  // interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SPF_IDLE, SPF_SEND, SPF_GAP} spf_state_e;

  logic [15:0] stream_packet_size;
  logic [31:0] inter_packet_gap_ticks;
  logic [31:0] stream_destination_ip;
  logic [15:0] keepalive_timeout_ms;
  logic keepalive_disable;
  logic stream_en;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  spf_state_e state;
  logic [15:0] byte_cnt;
  logic [31:0] gap_cnt;
  logic [15:0] ka_left;
  logic ev_pkt_done;
  logic ev_ka_expired;
  logic ms_tick;
  logic wr_en;
  logic rd_en;
  logic reopen;

  function automatic logic is_mcast(input logic [31:0] ip);
    return ip[31:24] >= MCAST_LO && ip[31:24] <= MCAST_HI;
  endfunction

  function automatic logic [15:0] clamp_ms(input logic [15:0] v);
    if (v < KA_MIN_MS) begin
      return KA_MIN_MS;
    end else if (v > KA_MAX_MS) begin
      return KA_MAX_MS;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // apb access
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign reopen = wr_en && paddr == OFS_CTRL && pwdata[CTRL_LINK_REOPEN];

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      unique case (paddr)
        OFS_PKT_SIZE, OFS_GAP, OFS_DEST_IP, OFS_TICK_RATE, OFS_KA_TIMEOUT,
        OFS_CTRL, OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK: pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stream_packet_size <= RST_PKT_SIZE; // R2
      inter_packet_gap_ticks <= RST_GAP; // R4
      stream_destination_ip <= RST_DEST_IP;
      keepalive_timeout_ms <= RST_KA_TIMEOUT; // R12
      keepalive_disable <= 1'b0; // R13
      stream_en <= 1'b0;
      irq_mask <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_PKT_SIZE: stream_packet_size <= pwdata[15:0];
        OFS_GAP: inter_packet_gap_ticks <= pwdata; // R6
        OFS_DEST_IP: stream_destination_ip <= pwdata;
        OFS_KA_TIMEOUT: keepalive_timeout_ms <= clamp_ms(pwdata[15:0]); // R11
        OFS_CTRL: begin
          keepalive_disable <= pwdata[CTRL_KA_DIS];
          stream_en <= pwdata[CTRL_STREAM_EN];
        end
        OFS_IRQ_MASK: irq_mask <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OFS_PKT_SIZE: prdata <= {16'h0000, stream_packet_size};
        OFS_GAP: prdata <= inter_packet_gap_ticks;
        OFS_DEST_IP: prdata <= stream_destination_ip;
        OFS_TICK_RATE: prdata <= TICK_RATE_HZ; // R5
        OFS_KA_TIMEOUT: prdata <= {16'h0000, keepalive_timeout_ms};
        OFS_CTRL: prdata <= {30'h0, stream_en, keepalive_disable};
        OFS_STATUS: prdata <= {28'h0, tx_multicast, ka_error, link_open,
          state != SPF_IDLE};
        OFS_IRQ_STAT: prdata <= {30'h0, irq_stat};
        OFS_IRQ_MASK: prdata <= {30'h0, irq_mask};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= '0;
    end else begin
      // clear only what the read returned, so a setup-cycle event survives
      irq_stat <= ((rd_en && paddr == OFS_IRQ_STAT)
        ? (irq_stat & ~prdata[IRQ_W-1:0]) : irq_stat)
        | {ev_ka_expired, ev_pkt_done};
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------
  // packet pacing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= SPF_IDLE;
      byte_cnt <= 16'h0000;
      gap_cnt <= 32'h0000_0000;
      tx_dest_ip <= 32'h0000_0000;
      tx_multicast <= 1'b0;
    end else begin
      unique case (state)
        SPF_IDLE: begin
          if (stream_en && frame_data_pending && stream_packet_size != 16'h0000) begin
            state <= SPF_SEND;
            byte_cnt <= 16'h0000;
            tx_dest_ip <= stream_destination_ip; // R7
            tx_multicast <= is_mcast(stream_destination_ip); // R8
          end
        end
        SPF_SEND: begin
          if (tx_byte_ready) begin
            byte_cnt <= byte_cnt + 16'h0001;
            if (tx_last) begin
              gap_cnt <= 32'h0000_0000; // R14
              state <= (inter_packet_gap_ticks == 32'h0) ? SPF_IDLE : SPF_GAP; // R6
            end
          end
        end
        SPF_GAP: begin
          gap_cnt <= gap_cnt + 32'h0000_0001;
          // a gap shrunk below the running count ends at once instead of wrapping
          if ({1'b0, gap_cnt} + 33'h0_0000_0001 >= {1'b0, inter_packet_gap_ticks}) begin
            state <= SPF_IDLE; // R3
          end
        end
        default: state <= SPF_IDLE;
      endcase
    end
  end

  assign tx_byte_valid = state == SPF_SEND;
  assign tx_first = tx_byte_valid && byte_cnt == 16'h0000;
  assign tx_last = tx_byte_valid && byte_cnt == stream_packet_size - 16'h1; // R1
  assign ev_pkt_done = tx_last && tx_byte_ready;

  // ----------------------------------------------------------------
  // keepalive supervision
  // ----------------------------------------------------------------
  spf_ms_timer #(.CYC_MS(CYC_MS)) u_ms (
    .clk(clk),
    .resetn(resetn),
    .restart(ctrl_msg_valid),
    .ms_tick(ms_tick)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ka_left <= RST_KA_TIMEOUT;
      link_open <= 1'b1;
      ka_error <= 1'b0;
    end else begin
      if (ctrl_msg_valid || reopen) begin
        ka_left <= keepalive_timeout_ms; // R15
      end else if (ms_tick && ka_left != 16'h0000) begin
        ka_left <= ka_left - 16'h0001; // R11
      end
      if (reopen) begin
        link_open <= 1'b1;
        ka_error <= 1'b0;
      end else if (ev_ka_expired) begin
        link_open <= 1'b0; // R10
        ka_error <= 1'b1;
      end
    end
  end

  // R9 relies on the host sending within the timeout; R13 gating below
  assign ev_ka_expired = link_open && !keepalive_disable && ka_left == 16'h0000; // R13

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_gap_idle;
    @(posedge clk) disable iff (!resetn)
      (ev_pkt_done && inter_packet_gap_ticks == 32'h0000_0005) |=> !tx_byte_valid [*5];
  endproperty
  a_gap_idle: assert property (p_gap_idle) else $error("gap too short"); // R3

  property p_gap_restart;
    @(posedge clk) disable iff (!resetn)
      (ev_pkt_done && inter_packet_gap_ticks != 32'h0) |=> gap_cnt == 32'h0;
  endproperty
  a_gap_restart: assert property (p_gap_restart) else $error("gap not restarted"); // R14

  property p_zero_gap;
    @(posedge clk) disable iff (!resetn)
      (ev_pkt_done && inter_packet_gap_ticks == 32'h0) |=> state == SPF_IDLE;
  endproperty
  a_zero_gap: assert property (p_zero_gap) else $error("zero gap stalled"); // R6

  property p_last_count;
    @(posedge clk) disable iff (!resetn)
      tx_last |-> byte_cnt == stream_packet_size - 16'h1;
  endproperty
  a_last_count: assert property (p_last_count) else $error("bad packet length"); // R1

  property p_mcast;
    @(posedge clk) disable iff (!resetn)
      tx_byte_valid |-> tx_multicast == is_mcast(tx_dest_ip);
  endproperty
  a_mcast: assert property (p_mcast) else $error("multicast flag wrong"); // R8

  property p_dest;
    @(posedge clk) disable iff (!resetn)
      (state == SPF_IDLE && $past(state) == SPF_IDLE) ##1 (state == SPF_SEND)
        |-> tx_dest_ip == $past(stream_destination_ip);
  endproperty
  a_dest: assert property (p_dest) else $error("destination not latched"); // R7

  property p_expire;
    @(posedge clk) disable iff (!resetn)
      (link_open && !keepalive_disable && ka_left == 16'h0 && !reopen)
        |=> !link_open && ka_error;
  endproperty
  a_expire: assert property (p_expire) else $error("link not dropped"); // R10

  property p_disable;
    @(posedge clk) disable iff (!resetn)
      (keepalive_disable && link_open && !ev_pkt_done) |=> link_open;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled timer closed link"); // R13

  property p_reload;
    @(posedge clk) disable iff (!resetn)
      ctrl_msg_valid |=> ka_left == $past(keepalive_timeout_ms);
  endproperty
  a_reload: assert property (p_reload) else $error("timer not reloaded"); // R15

  property p_range;
    @(posedge clk) disable iff (!resetn)
      keepalive_timeout_ms >= KA_MIN_MS && keepalive_timeout_ms <= KA_MAX_MS;
  endproperty
  a_range: assert property (p_range) else $error("timeout out of range"); // R11

  property p_gap_after;
    @(posedge clk) disable iff (!resetn)
      ev_pkt_done |=> !tx_byte_valid;
  endproperty
  a_gap_after: assert property (p_gap_after) else $error("no idle after packet"); // R14

  property p_dest_hold;
    @(posedge clk) disable iff (!resetn)
      (tx_byte_valid && !tx_first) |-> $stable(tx_dest_ip) && $stable(tx_multicast);
  endproperty
  a_dest_hold: assert property (p_dest_hold) else $error("destination moved in packet"); // R7

  property p_first_last;
    @(posedge clk) disable iff (!resetn)
      tx_last |-> (!tx_first || stream_packet_size == 16'h0001);
  endproperty
  a_first_last: assert property (p_first_last) else $error("packet ended too early"); // R1

  property p_ka_sticky;
    @(posedge clk) disable iff (!resetn)
      (ev_ka_expired && !reopen) |=> irq_stat[IRQ_KA_EXPIRED] && ka_error;
  endproperty
  a_ka_sticky: assert property (p_ka_sticky) else $error("expiry not recorded"); // R10

  property p_closed;
    @(posedge clk) disable iff (!resetn)
      (!link_open && !reopen) |=> !link_open;
  endproperty
  a_closed: assert property (p_closed) else $error("link reopened by itself"); // R10

  c_packet: cover property (@(posedge clk) disable iff (!resetn) ev_pkt_done);
  c_expire: cover property (@(posedge clk) disable iff (!resetn) ev_ka_expired);
  c_mcast: cover property (@(posedge clk) disable iff (!resetn)
    tx_first && tx_multicast);
  c_zero_gap: cover property (@(posedge clk) disable iff (!resetn)
    ev_pkt_done && inter_packet_gap_ticks == 32'h0);
  c_reopen: cover property (@(posedge clk) disable iff (!resetn) reopen && !link_open);
endmodule

// >>> testbench/spf_host_model.sv
// host-side partner: byte sink for the transmitter and keepalive talker
// assumes the bench steers stall and talk on the same clock
`timescale 1ns/1ps
module spf_host_model #(
  parameter int KA_PERIOD = 1000
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // steering from the bench
  input wire logic stall,
  input wire logic talk,
  // transmitter and control link
  output logic tx_byte_ready,
  output logic ctrl_msg_valid
);
  int cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_byte_ready <= 1'b0;
      ctrl_msg_valid <= 1'b0;
      cnt <= 0;
    end else begin
      tx_byte_ready <= !stall;
      cnt <= (talk && cnt < KA_PERIOD - 1) ? cnt + 1 : 0;
      ctrl_msg_valid <= talk && cnt == KA_PERIOD - 1;
    end
  end
endmodule

// >>> testbench/spf_stream_pacer_tb.sv
// self-checking bench for the stream pacer
// assumes spf_pkg, the pacer and the host partner model compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module spf_stream_pacer_tb import spf_pkg::*; ;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, frame_data_pending = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, tx_dest_ip, d;
  logic pready, pslverr, tx_byte_valid, tx_byte_ready, tx_first, tx_last, tx_multicast;
  logic ctrl_msg_valid, link_open, ka_error, irq, stall = 0, talk = 0, gchk = 0;
  logic [32:0] rd_q[$];
  logic [48:0] pk_q[$];
  logic [32:0] er;
  logic [48:0] ep;
  logic [31:0] seed = 32'h00008C04;
  logic [15:0] sz;
  int mismatches = 0, compares = 0, idle = 0, nb = 0, exp_gap = 0;
  logic [7:0] ofs[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h40};
  logic [32:0] rv[10] = '{33'h578, 33'h190, 33'h0, 33'h7735940, 33'hBB8, 33'h0, 33'h2, 33'h0,
    33'h0, 33'h100000000};
  logic [7:0] dst[4] = '{8'hDF, 8'hE0, 8'hEF, 8'hF0};
  logic [31:0] gp[2] = '{32'h5, 32'h0};

  spf_stream_pacer #(.CYC_MS(4)) spf_stream_pacer_inst (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_data_pending(frame_data_pending), .tx_byte_valid(tx_byte_valid),
    .tx_byte_ready(tx_byte_ready), .tx_first(tx_first), .tx_last(tx_last),
    .tx_dest_ip(tx_dest_ip), .tx_multicast(tx_multicast), .ctrl_msg_valid(ctrl_msg_valid),
    .link_open(link_open), .ka_error(ka_error), .irq(irq));
  spf_host_model spf_host_model_inst (.clk(clk), .resetn(resetn), .stall(stall), .talk(talk),
    .tx_byte_ready(tx_byte_ready), .ctrl_msg_valid(ctrl_msg_valid));

  // ----------------------------------------------------------------
  // clock, random source, bus cycles
  // ----------------------------------------------------------------
  initial begin
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  always @(posedge clk) stall <= (xs() < 32'h40000000);
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    input logic [32:0] e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    if (!w) rd_q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic finish_test();
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // output watchers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
      er = rd_q.pop_front();
      `CHK({pslverr, prdata}, er)
    end
    if (tx_byte_valid && tx_byte_ready) begin
      if (tx_first && gchk) `CHK(idle, exp_gap + 1)
      nb = tx_first ? 1 : nb + 1;
      idle = 0;
      if (tx_last && pk_q.size() > 0) begin
        ep = pk_q.pop_front();
        `CHK({tx_multicast, tx_dest_ip, nb[15:0]}, ep)
      end
    end else if (!tx_byte_valid) begin
      idle = idle + 1;
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    frame_data_pending <= 1'b1;
    talk <= 1'b1;
    foreach (ofs[i]) apb(1'b0, ofs[i], 32'h0, rv[i]);
    apb(1'b1, OFS_TICK_RATE, 32'h0, 33'h0);
    apb(1'b0, OFS_TICK_RATE, 32'h0, 33'h7735940);
    apb(1'b1, OFS_KA_TIMEOUT, 32'h64, 33'h0);
    apb(1'b0, OFS_KA_TIMEOUT, 32'h0, 33'h1F4);
    apb(1'b1, OFS_KA_TIMEOUT, 32'h4E20, 33'h0);
    apb(1'b0, OFS_KA_TIMEOUT, 32'h0, 33'h2710);
    apb(1'b1, OFS_KA_TIMEOUT, 32'h1F4, 33'h0);
    // one packet per destination, multicast edges included
    foreach (dst[i]) begin
      d = xs();
      d[31:24] = dst[i];
      sz = 16'(xs() % 9) + 16'h0002;
      apb(1'b1, OFS_PKT_SIZE, {16'h0, sz}, 33'h0);
      apb(1'b1, OFS_DEST_IP, d, 33'h0);
      pk_q.push_back({dst[i] >= 8'hE0 && dst[i] <= 8'hEF, d, sz});
      apb(1'b1, OFS_CTRL, 32'h2, 33'h0);
      while (pk_q.size() != 0) @(posedge clk);
      apb(1'b1, OFS_CTRL, 32'h0, 33'h0);
    end
    // back-to-back packets with a short and a zero gap
    foreach (gp[i]) begin
      exp_gap = gp[i];
      apb(1'b1, OFS_GAP, gp[i], 33'h0);
      apb(1'b1, OFS_PKT_SIZE, 32'h3, 33'h0);
      repeat (5) pk_q.push_back({1'b0, d, 16'h0003});
      apb(1'b1, OFS_CTRL, 32'h2, 33'h0);
      @(posedge clk iff (tx_last && tx_byte_valid && tx_byte_ready));
      gchk <= 1'b1;
      while (pk_q.size() != 0) @(posedge clk);
      gchk <= 1'b0;
      apb(1'b1, OFS_CTRL, 32'h0, 33'h0);
      repeat (40) @(posedge clk);
    end
    // packet-done interrupt: masked, unmasked, cleared by read
    `CHK(irq, 1'b0)
    apb(1'b1, OFS_IRQ_MASK, 32'h1, 33'h0);
    @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1'b0, OFS_IRQ_STAT, 32'h0, 33'h1);
    @(posedge clk);
    `CHK(irq, 1'b0)
    // keepalive: kept alive, then expiry, then disabled
    apb(1'b1, OFS_IRQ_MASK, 32'h2, 33'h0);
    repeat (6000) @(posedge clk);
    `CHK(link_open, 1'b1)
    @(posedge clk iff ctrl_msg_valid);
    talk <= 1'b0;
    repeat (1900) @(posedge clk);
    `CHK(link_open, 1'b1)
    repeat (200) @(posedge clk);
    `CHK({link_open, ka_error, irq}, 3'b011)
    apb(1'b0, OFS_IRQ_STAT, 32'h0, 33'h2);
    @(posedge clk);
    `CHK(irq, 1'b0)
    apb(1'b1, OFS_CTRL, 32'h5, 33'h0);
    repeat (3000) @(posedge clk);
    `CHK(link_open, 1'b1)
    finish_test();
  end
endmodule
